// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the host select and modem pin block.
// Assumes: Inputs change at the falling edge of the clock.
// Notes: Status level bits read one while the modem line is asserted.
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, rst = 1, sa = 1, sb = 1, sl_n = 0, as_n = 0, rd = 0, wr = 0, dtr_bit = 0;
	logic lpbk = 0, irq_en = 0, auto = 0, tx_req = 0, rx_err = 0, rx_dat = 0, rx_to = 0;
	logic fifo = 0, thr = 0;
	logic [2:0] rs = 3'h6, want = 3'h0;
	logic [7:0] din = 8'h5A, rdd = 8'hC3;
	wire [7:0] dout, ms;
	wire [2:0] sadr;
	wire doe, srd, swr, tdis_n, cts_n, dsr_n, dcd_n, dtr_n, txgo, irq, ready;
	int errors = 0, n_compared = 0;
	always #2 clk = ~clk;
	uhsm_host_modem uhsm_host_modem_inst (.REF_CLK(clk), .RST(rst), .SELECT_HIGH_A(sa),
		.SELECT_HIGH_B(sb), .SELECT_LOW_N(sl_n), .ADDRESS_LATCH_STROBE_N(as_n),
		.REGISTER_SELECT(rs), .RD(rd), .WR(wr), .D_IN(din), .D_OUT(dout), .D_OE(doe),
		.RD_DATA(rdd), .SEL_RD(srd), .SEL_WR(swr), .SEL_ADDR(sadr),
		.TRANSCEIVER_DISABLE_N(tdis_n), .CTS_N(cts_n), .DSR_N(dsr_n), .DCD_N(dcd_n),
		.DTR_N(dtr_n), .DTR_BIT(dtr_bit), .LOOPBACK(lpbk), .MODEM_IRQ_EN(irq_en),
		.AUTO_CTS_EN(auto), .TX_REQ(tx_req), .TX_GO(txgo), .RX_ERR_IRQ(rx_err),
		.RX_DATA_IRQ(rx_dat), .RX_TIMEOUT_IRQ(rx_to), .FIFO_MODE(fifo),
		.THR_EMPTY_IRQ(thr), .MODEM_STATUS(ms), .INT(irq));
	uhsm_modem_model uhsm_modem_model_inst (.want(want), .dtr_n(dtr_n), .cts_n(cts_n),
		.dsr_n(dsr_n), .dcd_n(dcd_n), .ready(ready));
	task chk(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task nc(input int n);
		repeat (n) @(negedge clk);
	endtask
	function automatic logic [7:0] stat(input logic [2:0] f);
		stat = {want[2], 1'b0, want[1], want[0], f[2], 1'b0, f[1], f[0]};
	endfunction
	task rd_stat(input logic [7:0] exp);
		rd = 1;
		nc(1);
		chk(doe, 1);
		chk(dout, exp);
		rd = 0;
		nc(1);
	endtask
	task t_sel;
		rs = 3'h2;
		for (int i = 0; i < 8; i++) begin
			{sa, sb, sl_n} = i[2:0];
			rd = 1;
			nc(1);
			chk(tdis_n, i == 6);
			chk(srd, i == 6);
			chk(doe, i == 6);
			if (i == 6) chk(dout, rdd);
			rd = 0;
			wr = 1;
			nc(1);
			chk(swr, i == 6);
			chk({doe, tdis_n}, 0);
			wr = 0;
		end
		{sa, sb, sl_n} = 3'h6;
		rs = 3'h6;
		$display("select test done");
	endtask
	task t_strobe;
		nc(1);
		as_n = 1;
		{sa, sb, sl_n} = 3'h0;
		rs = 3'h2;
		rd = 1;
		nc(1);
		chk({srd, sadr}, 4'hE);
		rd = 0;
		as_n = 0;
		nc(1);
		chk(sadr, 3'h2);
		{sa, sb, sl_n} = 3'h6;
		rs = 3'h6;
		$display("strobe test done");
	endtask
	task t_modem;
		irq_en = 1;
		for (int k = 0; k < 3; k++) begin
			want[k] = 1;
			nc(2);
			chk(ms, stat(3'h1 << k));
			nc(1);
			chk(irq, 1);
			rd_stat(stat(3'h1 << k));
			chk(ms, stat(0));
			nc(1);
			chk(irq, 0);
		end
		auto = 1;
		want[0] = 0;
		nc(3);
		chk({irq, ms}, stat(3'h1));
		irq_en = 0;
		want[1] = 0;
		nc(3);
		chk({irq, ms}, stat(3'h3));
		rd_stat(stat(3'h3));
		chk(ms, stat(0));
		auto = 0;
		$display("modem test done");
	endtask
	task t_tx;
		tx_req = 1;
		for (int m = 0; m < 4; m++) begin
			{auto, want[0]} = m[1:0];
			nc(1);
			chk(txgo, !auto || want[0]);
		end
		tx_req = 0;
		nc(1);
		chk(txgo, 0);
		auto = 0;
		$display("transmit gate test done");
	endtask
	task t_irq;
		fifo = 1;
		for (int j = 0; j < 5; j++) begin
			if (j == 4) fifo = 0;
			{rx_err, rx_dat, rx_to, thr} = 4'h1 << ((j == 4) ? 1 : j);
			nc(2);
			chk(irq, j != 4);
			{rx_err, rx_dat, rx_to, thr} = 4'h0;
			nc(2);
			chk(irq, 0);
		end
		$display("interrupt test done");
	endtask
	task t_dtr;
		nc(1);
		dtr_bit = 1;
		nc(2);
		chk({dtr_n, ready}, 1);
		lpbk = 1;
		nc(2);
		chk(dtr_n, 1);
		lpbk = 0;
		thr = 1;
		nc(2);
		chk({dtr_n, irq}, 1);
		rst = 1;
		nc(2);
		chk({dtr_n, irq, doe}, 3'h4);
		rst = 0;
		dtr_bit = 0;
		thr = 0;
		nc(2);
		chk(dtr_n, 1);
		$display("terminal ready test done");
	endtask
	task results;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		nc(6);
		rst = 0;
		nc(1);
		t_sel();
		t_strobe();
		t_modem();
		t_tx();
		t_irq();
		t_dtr();
		results();
	end
	// The whole run takes about 90 cycles, so this margin only trips on a hang.
	initial begin
		#20000;
		errors++;
		results();
	end
endmodule

// ==== verif/uhsm_modem_model.sv ====
// Purpose: Modem or data set facing the handshake pins of the block.
// Assumes: The bench changes the asserted lines off the sampling edge.
// Notes: All modem lines are active low and always driven.
`timescale 1ns/1ps
module uhsm_modem_model (
	input wire logic [2:0] want, // Lines to assert: carrier, set ready, clear to send.
	input wire logic dtr_n, // Terminal ready from the device.
	output logic cts_n, // Clear to send.
	output logic dsr_n, // Data set ready.
	output logic dcd_n, // Carrier detect.
	output logic ready // High while the device says it is ready.
);
	assign {dcd_n, dsr_n, cts_n} = ~want;
	assign ready = ~dtr_n;
endmodule

// ==== verilog/uhsm_consts.svh ====
// Purpose: Constants for the host select and modem pin block.
// Assumes: Single clock REF_CLK at 250 MHz.
// Notes: Bit positions of the modem status byte and select codes.
`ifndef UHSM_CONSTS_SVH
`define UHSM_CONSTS_SVH
`define UHSM_MSR_DCTS 0
`define UHSM_MSR_DDSR 1
`define UHSM_MSR_DDCD 3
`define UHSM_MSR_CTS 4
`define UHSM_MSR_DSR 5
`define UHSM_MSR_DCD 7
`define UHSM_MSR_RST 8'h00
`define UHSM_SEL_MSR 3'h6
`endif

// ==== verilog/uhsm_host_modem.sv ====
// Purpose: Chip select, data bus, interrupt and modem handshake pins of a UART.
// Assumes: All inputs synchronous to REF_CLK; modem pins active low.
// Notes: Register map beyond the modem status byte lives elsewhere.
// Notes on behaviour
// - Selected only when both high selects are high and the low select is low.
// - Unselected device ignores reads and writes and leaves data undriven.
// - Status bit 4 shows clear-to-send; bit 0 flags its change since read.
// - Clear-to-send change interrupts only if enabled and auto mode off.
// - In auto mode clear-to-send gates the transmitter.
// - Bit 7 shows carrier detect, bit 3 its change; change may interrupt.
// - Bit 5 shows data-set-ready, bit 1 its change; change may interrupt.
// - Eight-bit three-state bidirectional data bus to the CPU.
// - Transceiver disable is low whenever the CPU is not reading.
// - Data-terminal-ready output is low when its control bit is set.
// - Data-terminal-ready inactive on reset, in loopback, or bit cleared.
// - A pending interrupt drives the interrupt output high.
// - Receiver error, data, FIFO-mode timeout, transmit empty or modem change interrupt.
// - Interrupt drops once serviced or on master reset.
// - Address strobe low passes selects through; rising edge holds them.
`timescale 1ns/1ps
`include "uhsm_consts.svh"
module uhsm_host_modem
	import uhsm_pkg::*;
(
	input wire logic REF_CLK, // Device clock.
	input wire logic RST, // Synchronous master reset, active high.
	input wire logic SELECT_HIGH_A, // Chip select, active high.
	input wire logic SELECT_HIGH_B, // Chip select, active high.
	input wire logic SELECT_LOW_N, // Chip select, active low.
	input wire logic ADDRESS_LATCH_STROBE_N, // Address strobe, active low.
	input wire logic [2:0] REGISTER_SELECT, // Register select.
	input wire logic RD, // CPU read strobe, active high.
	input wire logic WR, // CPU write strobe, active high.
	input wire logic [7:0] D_IN, // Data bus input.
	output logic [7:0] D_OUT, // Data bus output.
	output logic D_OE, // Data bus output enable.
	input wire logic [7:0] RD_DATA, // Read data from other registers.
	output logic SEL_RD, // Selected read, pulse per cycle.
	output logic SEL_WR, // Selected write, pulse per cycle.
	output logic [2:0] SEL_ADDR, // Latched register select.
	output logic TRANSCEIVER_DISABLE_N, // Low when CPU is not reading.
	input wire logic CTS_N, // Clear to send, active low.
	input wire logic DSR_N, // Data set ready, active low.
	input wire logic DCD_N, // Carrier detect, active low.
	output logic DTR_N, // Data terminal ready, active low.
	input wire logic DTR_BIT, // Control register data-terminal-ready bit.
	input wire logic LOOPBACK, // Loopback mode.
	input wire logic MODEM_IRQ_EN, // Modem status interrupt enable.
	input wire logic AUTO_CTS_EN, // Automatic clear-to-send mode.
	input wire logic TX_REQ, // Transmitter wants to send.
	output logic TX_GO, // Transmitter may proceed.
	input wire logic RX_ERR_IRQ, // Receiver error source.
	input wire logic RX_DATA_IRQ, // Received data source.
	input wire logic RX_TIMEOUT_IRQ, // Receive timeout source.
	input wire logic FIFO_MODE, // FIFO mode enable.
	input wire logic THR_EMPTY_IRQ, // Transmit holding empty source.
	output logic [7:0] MODEM_STATUS, // Modem status byte.
	output logic INT // Interrupt to CPU, active high.
);

	// ----------------------------------------------------------------
	// Address and select latch
	// ----------------------------------------------------------------
	logic [2:0] addr_reg, addr_next;
	logic [2:0] cs_reg, cs_next;
	logic [2:0] addr_eff;
	logic sel;

	always_comb begin
		addr_next = addr_reg;
		cs_next = cs_reg;
		if (!ADDRESS_LATCH_STROBE_N) begin
			addr_next = REGISTER_SELECT;
			cs_next = {SELECT_HIGH_A, SELECT_HIGH_B, SELECT_LOW_N};
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			addr_reg <= 3'h0;
			cs_reg <= 3'h0;
		end else begin
			addr_reg <= addr_next;
			cs_reg <= cs_next;
		end
	end

	// Transparent while the strobe is low, held value once it goes high.
	always_comb begin
		if (!ADDRESS_LATCH_STROBE_N) begin
			addr_eff = REGISTER_SELECT;
			sel = SELECT_HIGH_A & SELECT_HIGH_B & ~SELECT_LOW_N;
		end else begin
			addr_eff = addr_reg;
			sel = cs_reg[2] & cs_reg[1] & ~cs_reg[0];
		end
	end

	assign SEL_RD = sel & RD;
	assign SEL_WR = sel & WR;
	assign SEL_ADDR = addr_eff;
	assign TRANSCEIVER_DISABLE_N = SEL_RD;

	// ----------------------------------------------------------------
	// Data bus
	// ----------------------------------------------------------------
	logic [7:0] dout_reg, dout_next;
	logic oe_reg, oe_next;
	logic [7:0] msr_reg, msr_next;
	logic msr_read;

	assign msr_read = SEL_RD & (addr_eff == `UHSM_SEL_MSR);

	always_comb begin
		oe_next = SEL_RD;
		dout_next = 8'h00;
		if (msr_read) begin
			dout_next = msr_reg;
		end else if (SEL_RD) begin
			dout_next = RD_DATA;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			dout_reg <= 8'h00;
			oe_reg <= 1'b0;
		end else begin
			dout_reg <= dout_next;
			oe_reg <= oe_next;
		end
	end

	assign D_OUT = dout_reg;
	assign D_OE = oe_reg & SEL_RD;

	// ----------------------------------------------------------------
	// Modem status
	// ----------------------------------------------------------------
	logic [2:0] pin_reg, pin_next;
	logic cts_chg, dsr_chg, dcd_chg;
	logic msr_rd_reg, msr_rd_next;

	assign pin_next = {~DCD_N, ~DSR_N, ~CTS_N};
	assign cts_chg = pin_next[0] ^ pin_reg[0];
	assign dsr_chg = pin_next[1] ^ pin_reg[1];
	assign dcd_chg = pin_next[2] ^ pin_reg[2];
	// A read clears flags once the read ends, so the CPU sees a stable byte.
	assign msr_rd_next = msr_read;

	always_comb begin
		msr_next = msr_reg;
		msr_next[`UHSM_MSR_CTS] = pin_next[0];
		msr_next[`UHSM_MSR_DSR] = pin_next[1];
		msr_next[`UHSM_MSR_DCD] = pin_next[2];
		if (msr_rd_reg && !msr_read) begin
			msr_next[`UHSM_MSR_DCTS] = 1'b0;
			msr_next[`UHSM_MSR_DDSR] = 1'b0;
			msr_next[`UHSM_MSR_DDCD] = 1'b0;
		end
		// Set wins over the read clear.
		if (cts_chg) msr_next[`UHSM_MSR_DCTS] = 1'b1;
		if (dsr_chg) msr_next[`UHSM_MSR_DDSR] = 1'b1;
		if (dcd_chg) msr_next[`UHSM_MSR_DDCD] = 1'b1;
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			msr_reg <= `UHSM_MSR_RST;
			pin_reg <= pin_next; // A pin already active at reset is not a change.
			msr_rd_reg <= 1'b0;
		end else begin
			msr_reg <= msr_next;
			pin_reg <= pin_next;
			msr_rd_reg <= msr_rd_next;
		end
	end

	assign MODEM_STATUS = msr_reg;

	// ----------------------------------------------------------------
	// Modem outputs and transmitter gate
	// ----------------------------------------------------------------
	logic dtr_reg, dtr_next;

	assign dtr_next = ~(DTR_BIT & ~LOOPBACK);

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			dtr_reg <= 1'b1;
		end else begin
			dtr_reg <= dtr_next;
		end
	end

	assign DTR_N = dtr_reg;
	assign TX_GO = TX_REQ & (~AUTO_CTS_EN | ~CTS_N);

	// ----------------------------------------------------------------
	// Interrupt
	// ----------------------------------------------------------------
	uhsm_irq_t irq_reg, irq_next;
	logic modem_src;
	logic any_src;

	// Auto mode hides the clear-to-send flag from the interrupt only.
	assign modem_src = MODEM_IRQ_EN & ((msr_reg[`UHSM_MSR_DCTS] & ~AUTO_CTS_EN)
		| msr_reg[`UHSM_MSR_DDSR] | msr_reg[`UHSM_MSR_DDCD]);
	assign any_src = RX_ERR_IRQ | RX_DATA_IRQ | (RX_TIMEOUT_IRQ & FIFO_MODE)
		| THR_EMPTY_IRQ | modem_src;

	always_comb begin
		case (irq_reg)
			UHSM_IRQ_IDLE: irq_next = any_src ? UHSM_IRQ_PEND : UHSM_IRQ_IDLE;
			UHSM_IRQ_PEND: irq_next = any_src ? UHSM_IRQ_PEND : UHSM_IRQ_IDLE;
			default: irq_next = UHSM_IRQ_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			irq_reg <= UHSM_IRQ_IDLE;
		end else begin
			irq_reg <= irq_next;
		end
	end

	assign INT = (irq_reg == UHSM_IRQ_PEND);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_unsel_quiet;
		@(posedge REF_CLK) disable iff (RST) !sel |-> !D_OE && !SEL_WR;
	endproperty
	a_unsel_quiet: assert property (p_unsel_quiet) else $error("bus active unselected");

	property p_cts_level;
		@(posedge REF_CLK) disable iff (RST) 1'b1 |=> msr_reg[`UHSM_MSR_CTS] == !$past(CTS_N);
	endproperty
	a_cts_level: assert property (p_cts_level) else $error("cts level wrong");

	property p_cts_flag;
		@(posedge REF_CLK) disable iff (RST) $changed(CTS_N) && !$past(RST) |=> msr_reg[`UHSM_MSR_DCTS];
	endproperty
	a_cts_flag: assert property (p_cts_flag) else $error("cts change lost");

	property p_auto_cts;
		@(posedge REF_CLK) disable iff (RST) AUTO_CTS_EN && CTS_N |-> !TX_GO;
	endproperty
	a_auto_cts: assert property (p_auto_cts) else $error("tx not gated");

	sequence s_dcd_change;
		$changed(DCD_N) && !$past(RST);
	endsequence
	property p_dcd_irq;
		@(posedge REF_CLK) disable iff (RST)
			(s_dcd_change and MODEM_IRQ_EN) ##1 MODEM_IRQ_EN |=> INT;
	endproperty
	a_dcd_irq: assert property (p_dcd_irq) else $error("dcd irq missing");

	property p_dsr_flag;
		@(posedge REF_CLK) disable iff (RST) $changed(DSR_N) && !$past(RST) |=> msr_reg[`UHSM_MSR_DDSR];
	endproperty
	a_dsr_flag: assert property (p_dsr_flag) else $error("dsr change lost");

	property p_transceiver_disable_n;
		@(posedge REF_CLK) disable iff (RST) !RD |-> !TRANSCEIVER_DISABLE_N;
	endproperty
	a_transceiver_disable_n: assert property (p_transceiver_disable_n) else $error("transceiver not disabled");

	property p_dtr_loop;
		@(posedge REF_CLK) disable iff (RST) LOOPBACK ##1 LOOPBACK |-> DTR_N;
	endproperty
	a_dtr_loop: assert property (p_dtr_loop) else $error("dtr active in loop");

	property p_int_drop;
		@(posedge REF_CLK) disable iff (RST) !any_src |=> !INT;
	endproperty
	a_int_drop: assert property (p_int_drop) else $error("int stuck");

endmodule

// ==== verilog/uhsm_pkg.sv ====
// Purpose: Types for the host select and modem pin block.
// Assumes: Nothing beyond the constants header.
// Notes: Interrupt source state is a Gray-coded enum.
package uhsm_pkg;
	typedef enum logic [1:0] {
		UHSM_IRQ_IDLE = 2'h0,
		UHSM_IRQ_PEND = 2'h1
	} uhsm_irq_t;
endpackage
